/* File: brake_consts.svh */
`ifndef BRAKE_CONSTS_SVH
`define BRAKE_CONSTS_SVH

// Register byte offsets
`define REG_IN_SEL      8'h00
`define REG_OUT_SEL     8'h04
`define REG_START_DLY   8'h08
`define REG_DECEL_DLY   8'h0C
`define REG_ENGAGE_SPD  8'h10
`define REG_DC_TIME     8'h14
`define REG_FAULT_TIME  8'h18
`define REG_STATUS      8'h1C
`define REG_IRQ_STAT    8'h20
`define REG_IRQ_MASK    8'h24

// Terminal function codes
`define CODE_OPEN_DONE  8'h0F
`define CODE_REQ_POS    8'h14
`define CODE_REQ_NEG    8'h78

// Reset values
`define RST_IN_SEL      32'h0000_0000
`define RST_OUT_SEL     16'h0000
`define RST_DELAY       16'h0064
`define RST_ENGAGE_SPD  16'h0010

// Interrupt bit positions
`define IRQ_FAULT       0
`define IRQ_OPENED      1
`define IRQ_CLOSED      2
`define IRQ_BITS        3

// Timing: delays count a 1 us tick
`define CLK_PERIOD_NS   8
`define TICK_NS         1000
`define TICK_CYCLES     (`TICK_NS / `CLK_PERIOD_NS)

// Zero-speed braking frequency is fixed
`define DC_BRAKE_FREQ   16'h0000

`endif

/* File: brake_pkg.sv */
package brake_pkg;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_START_DLY = 3'b001,
    ST_RUN       = 3'b010,
    ST_ZONE      = 3'b011,
    ST_DECEL_DLY = 3'b100,
    ST_DC_HOLD   = 3'b101
  } brake_state_t;

endpackage

/* File: brake_delay_timer.sv */
`timescale 1ns/1ps
module brake_delay_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Control
  input  wire logic         tick_in,
  input  wire logic         start_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] limit_in,
  // Status
  output logic              running_out,
  output logic              done_out
);

  logic [W-1:0] count_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      count_reg   <= '0;
      running_out <= 1'b0;
      done_out    <= 1'b0;
    end else if (start_in) begin
      count_reg   <= '0;
      running_out <= 1'b1;
      done_out    <= 1'b0;
    end else if (running_out && tick_in) begin
      // Expiry stops and clears the count
      if (count_reg + 1'b1 >= limit_in || limit_in == '0) begin
        count_reg   <= '0;
        running_out <= 1'b0;
        done_out    <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
        done_out  <= 1'b0;
      end
    end else begin
      done_out <= 1'b0;
    end
  end

endmodule

/* File: brake_sequence_controller.sv */
`timescale 1ns/1ps
`include "brake_consts.svh"
module brake_sequence_controller
  import brake_pkg::*;
#(
  parameter int N_IN  = 4,
  parameter int N_OUT = 2,
  parameter int SPD_W = 16
) (
  // Clock and reset
  input  wire logic             SYS_CLK_IN,
  input  wire logic             RST_IN,
  // APB slave
  input  wire logic             PSEL_IN,
  input  wire logic             PENABLE_IN,
  input  wire logic             PWRITE_IN,
  input  wire logic [7:0]       PADDR_IN,
  input  wire logic [31:0]      PWDATA_IN,
  output logic      [31:0]      PRDATA_OUT,
  output logic                  PREADY_OUT,
  output logic                  PSLVERR_OUT,
  // Pins
  input  wire logic [N_IN-1:0]  TERM_IN,
  input  wire logic             START_IN,
  input  wire logic             PREEXCITE_CMD_IN,
  output logic      [N_OUT-1:0] TERM_OUT,
  // Drive core, same clock
  input  wire logic             VECTOR_CTRL_IN,
  input  wire logic             FULL_CLOSED_IN,
  input  wire logic             POSITION_FEED_IN,
  input  wire logic             FLUX_REACHED_IN,
  input  wire logic             OUTPUT_SHUTOFF_IN,
  input  wire logic             DECEL_AT_TARGET_IN,
  input  wire logic             SYS_FAILURE_IN,
  input  wire logic             FEED_START_IN,
  input  wire logic [SPD_W-1:0] SPEED_IN,
  // Drive core controls
  output logic                  BRAKE_OPEN_REQUEST_OUT,
  output logic                  RAMP_ENABLE_OUT,
  output logic                  DC_BRAKE_OUT,
  output logic      [15:0]      DC_BRAKE_FREQ_OUT,
  // Interrupt
  output logic                  IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NS = N_IN + 2;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {PREEXCITE_CMD_IN, START_IN, TERM_IN};
      sync2_reg <= sync1_reg;
    end
  end

  logic            start_s;
  logic            preexc_s;
  logic            start_d_reg;
  logic [N_IN-1:0] term_s;
  assign term_s   = sync2_reg[N_IN-1:0];
  assign start_s  = sync2_reg[N_IN];
  assign preexc_s = sync2_reg[N_IN+1];

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      start_d_reg <= 1'b0;
    end else begin
      start_d_reg <= start_s;
    end
  end

  logic start_fall;
  assign start_fall = start_d_reg && !start_s;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]          in_sel_reg;
  logic [2*N_OUT*4-1:0] out_sel_reg;
  logic [15:0]          start_dly_reg;
  logic [15:0]          decel_dly_reg;
  logic [SPD_W-1:0]     engage_spd_reg;
  logic [15:0]          dc_time_reg;
  logic [15:0]          fault_time_reg;
  logic [`IRQ_BITS-1:0] irq_stat_reg;
  logic [`IRQ_BITS-1:0] irq_mask_reg;
  logic                 pready_reg;
  logic                 wr_en;
  logic                 rd_en;

  // One wait state keeps read data and ready straight from flops
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && pready_reg;
  assign rd_en = PSEL_IN && PENABLE_IN && !pready_reg;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      in_sel_reg     <= `RST_IN_SEL;
      out_sel_reg    <= `RST_OUT_SEL;
      start_dly_reg  <= `RST_DELAY;
      decel_dly_reg  <= `RST_DELAY;
      engage_spd_reg <= `RST_ENGAGE_SPD;
      dc_time_reg    <= `RST_DELAY;
      fault_time_reg <= `RST_DELAY;
      irq_mask_reg   <= '0;
    end else if (wr_en) begin
      if (PADDR_IN == `REG_IN_SEL) begin
        in_sel_reg <= PWDATA_IN;
      end else if (PADDR_IN == `REG_OUT_SEL) begin
        out_sel_reg <= PWDATA_IN[2*N_OUT*4-1:0];
      end else if (PADDR_IN == `REG_START_DLY) begin
        start_dly_reg <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `REG_DECEL_DLY) begin
        decel_dly_reg <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `REG_ENGAGE_SPD) begin
        engage_spd_reg <= PWDATA_IN[SPD_W-1:0];
      end else if (PADDR_IN == `REG_DC_TIME) begin
        dc_time_reg <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `REG_FAULT_TIME) begin
        fault_time_reg <= PWDATA_IN[15:0];
      end else if (PADDR_IN == `REG_IRQ_MASK) begin
        irq_mask_reg <= PWDATA_IN[`IRQ_BITS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick and terminal routing
  logic [7:0] tick_cnt_reg;
  logic       tick;
  assign tick = (tick_cnt_reg == 8'(`TICK_CYCLES - 1));

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end

  logic [N_IN-1:0] done_hit;
  logic            done_s;
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    assign done_hit[i] = (in_sel_reg[8*i +: 8] == `CODE_OPEN_DONE) && term_s[i];
  end
  assign done_s = |done_hit;

  logic req_reg;
  for (genvar j = 0; j < N_OUT; j++) begin : g_out
    always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
        TERM_OUT[j] <= 1'b0;
      end else if (out_sel_reg[8*j +: 8] == `CODE_REQ_POS) begin
        TERM_OUT[j] <= req_reg;
      end else if (out_sel_reg[8*j +: 8] == `CODE_REQ_NEG) begin
        TERM_OUT[j] <= !req_reg;
      end else begin
        TERM_OUT[j] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brake sequence
  brake_state_t state_reg;
  brake_state_t state_next;
  logic         req_next;
  logic         ramp_reg;
  logic         ramp_next;
  logic         dc_reg;
  logic         dc_next;
  logic         cause_reg;
  logic         relock_reg;
  logic         dc_ok;
  logic         seq_done;
  logic         seq_start;
  logic         seq_run;
  logic [15:0]  seq_limit;
  logic         zone_enter;

  // Full-closed hold needs vector control
  assign dc_ok = cause_reg && (!FULL_CLOSED_IN || VECTOR_CTRL_IN);
  assign zone_enter = start_fall || SYS_FAILURE_IN || (POSITION_FEED_IN && DECEL_AT_TARGET_IN);

  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    ramp_next  = ramp_reg;
    dc_next    = dc_reg;
    if (OUTPUT_SHUTOFF_IN) begin
      state_next = ST_IDLE;
      req_next   = 1'b0;
      ramp_next  = 1'b0;
      dc_next    = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (VECTOR_CTRL_IN && FLUX_REACHED_IN && (preexc_s || start_s) && !relock_reg) begin
            state_next = ST_START_DLY;
            req_next   = 1'b1;
          end
        end
        ST_START_DLY: begin
          // Only a start that rises inside the delay skips it; start-first waits
          if (start_s && !start_d_reg) begin
            ramp_next = 1'b1;
          end
          if (seq_done) begin
            state_next = ST_RUN;
            ramp_next  = 1'b1;
          end
        end
        ST_RUN: begin
          // Low speed alone never ends the feed
          if (zone_enter) begin
            state_next = ST_ZONE;
            ramp_next  = 1'b0;
          end
        end
        ST_ZONE: begin
          if (FEED_START_IN) begin
            state_next = ST_RUN;
            ramp_next  = 1'b1;
          end else if (SPEED_IN <= engage_spd_reg) begin
            state_next = ST_DECEL_DLY;
          end
        end
        ST_DECEL_DLY: begin
          if (FEED_START_IN) begin
            state_next = ST_RUN;
            ramp_next  = 1'b1;
          end else if (seq_done) begin
            req_next = 1'b0;
            if (dc_ok) begin
              state_next = ST_DC_HOLD;
              dc_next    = 1'b1;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_DC_HOLD: begin
          if (!done_s || seq_done) begin
            state_next = ST_IDLE;
            dc_next    = 1'b0;
          end
        end
        default: begin
          state_next = ST_IDLE;
          req_next   = 1'b0;
          ramp_next  = 1'b0;
          dc_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      req_reg   <= 1'b0;
      ramp_reg  <= 1'b0;
      dc_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      ramp_reg  <= ramp_next;
      dc_reg    <= dc_next;
    end
  end

  // Stop cause decides whether zero speed hold applies
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cause_reg <= 1'b0;
    end else if (state_reg == ST_RUN && zone_enter) begin
      cause_reg <= start_fall || SYS_FAILURE_IN;
    end
  end

  // Stop with request low needs pre-excite dropped once
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      relock_reg <= 1'b0;
    end else if (!preexc_s) begin
      relock_reg <= 1'b0;
    end else if (req_reg && !req_next) begin
      relock_reg <= 1'b1;
    end
  end

  assign seq_start = (state_next != state_reg) && !OUTPUT_SHUTOFF_IN &&
                     (state_next == ST_START_DLY || state_next == ST_DECEL_DLY || state_next == ST_DC_HOLD);
  assign seq_limit = (state_next == ST_START_DLY) ? start_dly_reg :
                     (state_next == ST_DECEL_DLY) ? decel_dly_reg : dc_time_reg;

  // Shared timer: only one sequence delay runs at a time
  brake_delay_timer #(.W(16)) u_seq_timer (
    .clk_in      (SYS_CLK_IN),
    .rst_in      (RST_IN),
    .tick_in     (tick),
    .start_in    (seq_start),
    .clear_in    (OUTPUT_SHUTOFF_IN || (FEED_START_IN && (state_reg == ST_ZONE || state_reg == ST_DECEL_DLY))),
    .limit_in    (seq_limit),
    .running_out (seq_run),
    .done_out    (seq_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequence fault check
  logic req_d_reg;
  logic fault_done;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      req_d_reg <= 1'b0;
    end else begin
      req_d_reg <= req_reg;
    end
  end

  brake_delay_timer #(.W(16)) u_fault_timer (
    .clk_in      (SYS_CLK_IN),
    .rst_in      (RST_IN),
    .tick_in     (tick),
    .start_in    (req_reg != req_d_reg),
    .clear_in    (done_s == req_reg && req_reg == req_d_reg),
    .limit_in    (fault_time_reg),
    .running_out (),
    .done_out    (fault_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and outputs
  logic [`IRQ_BITS-1:0] irq_ev;
  logic [`IRQ_BITS-1:0] irq_stat_next;
  logic [`IRQ_BITS-1:0] irq_w1c;

  assign irq_ev[`IRQ_FAULT]  = fault_done;
  assign irq_ev[`IRQ_OPENED] = req_reg && !req_d_reg;
  assign irq_ev[`IRQ_CLOSED] = !req_reg && req_d_reg;
  assign irq_w1c = (wr_en && PADDR_IN == `REG_IRQ_STAT) ? PWDATA_IN[`IRQ_BITS-1:0] : '0;
  // New events win over a same-cycle clear
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_ev;

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      irq_stat_reg           <= '0;
      IRQ_OUT                <= 1'b0;
      BRAKE_OPEN_REQUEST_OUT <= 1'b0;
      RAMP_ENABLE_OUT        <= 1'b0;
      DC_BRAKE_OUT           <= 1'b0;
      DC_BRAKE_FREQ_OUT      <= `DC_BRAKE_FREQ;
    end else begin
      irq_stat_reg           <= irq_stat_next;
      IRQ_OUT                <= |(irq_stat_next & irq_mask_reg);
      BRAKE_OPEN_REQUEST_OUT <= req_reg;
      RAMP_ENABLE_OUT        <= ramp_reg;
      DC_BRAKE_OUT           <= dc_reg;
      DC_BRAKE_FREQ_OUT      <= `DC_BRAKE_FREQ;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      pready_reg <= 1'b0;
      PRDATA_OUT <= '0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      pready_reg <= PSEL_IN && PENABLE_IN && !pready_reg;
      if (rd_en) begin
        PSLVERR_OUT <= 1'b0;
        if (PADDR_IN == `REG_IN_SEL) begin
          PRDATA_OUT <= in_sel_reg;
        end else if (PADDR_IN == `REG_OUT_SEL) begin
          PRDATA_OUT <= 32'(out_sel_reg);
        end else if (PADDR_IN == `REG_START_DLY) begin
          PRDATA_OUT <= {16'h0000, start_dly_reg};
        end else if (PADDR_IN == `REG_DECEL_DLY) begin
          PRDATA_OUT <= {16'h0000, decel_dly_reg};
        end else if (PADDR_IN == `REG_ENGAGE_SPD) begin
          PRDATA_OUT <= 32'(engage_spd_reg);
        end else if (PADDR_IN == `REG_DC_TIME) begin
          PRDATA_OUT <= {16'h0000, dc_time_reg};
        end else if (PADDR_IN == `REG_FAULT_TIME) begin
          PRDATA_OUT <= {16'h0000, fault_time_reg};
        end else if (PADDR_IN == `REG_STATUS) begin
          PRDATA_OUT <= {24'h00_0000, seq_run, state_reg, dc_reg, ramp_reg, done_s, req_reg};
        end else if (PADDR_IN == `REG_IRQ_STAT) begin
          PRDATA_OUT <= 32'(irq_stat_reg);
        end else if (PADDR_IN == `REG_IRQ_MASK) begin
          PRDATA_OUT <= 32'(irq_mask_reg);
        end else begin
          PRDATA_OUT  <= '0;
          PSLVERR_OUT <= 1'b1;
        end
      end
    end
  end

  assign PREADY_OUT = pready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence open_cond_s;
    state_reg == ST_IDLE && !OUTPUT_SHUTOFF_IN && VECTOR_CTRL_IN && FLUX_REACHED_IN &&
      (preexc_s || start_s) && !relock_reg;
  endsequence
  sequence open_seen_s;
    req_reg && state_reg == ST_START_DLY ##1 BRAKE_OPEN_REQUEST_OUT;
  endsequence

  flux_open_a:   assert property (open_cond_s |=> open_seen_s)
    else $error("request not raised after flux reached");
  shutoff_drop_a: assert property (OUTPUT_SHUTOFF_IN |=> !req_reg ##1 !BRAKE_OPEN_REQUEST_OUT)
    else $error("request still high after shutoff");
  term_route_a:  assert property (out_sel_reg[7:0] == `CODE_REQ_NEG && $stable(out_sel_reg)
                                  |=> TERM_OUT[0] == !$past(req_reg))
    else $error("inverted request terminal wrong");
  done_route_a:  assert property (in_sel_reg[7:0] == `CODE_OPEN_DONE && sync2_reg[0] |-> done_s)
    else $error("open-done terminal not routed");
  start_ramp_a:  assert property (state_reg == ST_START_DLY && start_s && !start_d_reg && !OUTPUT_SHUTOFF_IN
                                  |=> ramp_reg)
    else $error("start during delay did not ramp");
  low_speed_a:   assert property (state_reg == ST_RUN && !zone_enter && !OUTPUT_SHUTOFF_IN
                                  && SPEED_IN <= engage_spd_reg |=> req_reg && state_reg == ST_RUN)
    else $error("low speed ended the feed");
  decel_clear_a: assert property (state_reg == ST_DECEL_DLY && FEED_START_IN && !OUTPUT_SHUTOFF_IN
                                  |=> !seq_run && state_reg == ST_RUN)
    else $error("decel timer survived a new feed");
  dc_gate_a:     assert property ($rose(dc_reg) |-> $fell(req_reg) && cause_reg &&
                                  (!FULL_CLOSED_IN || $past(VECTOR_CTRL_IN)))
    else $error("zero speed hold without its cause");
  fault_flag_a:  assert property (fault_done |=> irq_stat_reg[`IRQ_FAULT])
    else $error("sequence fault not flagged");

endmodule

/* File: brake_model.sv */
`timescale 1ns/1ps
module brake_model #(
  parameter int LAG = 20
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Drive side
  input  wire logic request_in,
  input  wire logic stuck_in,
  // Brake feedback
  output logic      done_out
);
  int cnt_reg;

  // Mechanical lag: feedback follows the request LAG+1 cycles after they differ
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg  <= 0;
      done_out <= 1'b0;
    end else if (stuck_in || done_out == request_in) begin
      cnt_reg <= 0;
    end else if (cnt_reg == LAG) begin
      cnt_reg  <= 0;
      done_out <= request_in;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
endmodule

/* File: brake_sequence_controller_tb.sv */
`timescale 1ns/1ps
`include "brake_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module brake_sequence_controller_tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic        clk, rst, psel, penable, pwrite, start, lx, vec, pos, flux, shut, tgt, feed, stuck, fc;
  logic        pready, pslverr, req, ramp, dc, irq, done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] spd, dc_freq;
  logic [1:0]  term_out;
  int          errors = 0;
  int          n_compared = 0;
  note_t       notes[$];
  note_t       n;
  ////////////////////////////////////////////////////////////
  brake_sequence_controller i_brake_sequence_controller (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .TERM_IN({3'b000, done}), .START_IN(start), .PREEXCITE_CMD_IN(lx), .TERM_OUT(term_out),
    .VECTOR_CTRL_IN(vec), .FULL_CLOSED_IN(fc), .POSITION_FEED_IN(pos), .FLUX_REACHED_IN(flux),
    .OUTPUT_SHUTOFF_IN(shut), .DECEL_AT_TARGET_IN(tgt), .SYS_FAILURE_IN(1'b0), .FEED_START_IN(feed),
    .SPEED_IN(spd), .BRAKE_OPEN_REQUEST_OUT(req), .RAMP_ENABLE_OUT(ramp), .DC_BRAKE_OUT(dc),
    .DC_BRAKE_FREQ_OUT(dc_freq), .IRQ_OUT(irq));
  brake_model i_brake_model (.clk_in(clk), .rst_in(rst), .request_in(term_out[0]), .stuck_in(stuck), .done_out(done));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFF_FFFF,
                    input logic e = 1'b0);
    notes.push_back('{d, m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // No bound here: the watchdog cuts a hang short
  task automatic wait_req(input logic v);
    while (req !== v) @(posedge clk);
  endtask

  task automatic end_of_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data is checked against the oldest note when the slave answers
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = notes.pop_front();
      `CHK(prdata & n.m, n.d)
      `CHK(pslverr, n.e)
    end
  end

  initial begin
    #400_000;
    errors++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, start, lx, vec, pos, flux, shut, tgt, feed, stuck, fc} = '0;
    {paddr, pwdata, spd} = '0;
    rst = 1'b1;
    void'($urandom(32'h17b4_0697));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    rd(`REG_IN_SEL, `RST_IN_SEL);
    rd(`REG_START_DLY, 32'h0000_0064);
    rd(`REG_ENGAGE_SPD, 32'h0000_0010);
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    // Short delays keep the run brief
    apb(1'b1, `REG_IN_SEL, {24'h00_0000, `CODE_OPEN_DONE});
    apb(1'b1, `REG_OUT_SEL, {16'h0000, `CODE_REQ_NEG, `CODE_REQ_POS});
    apb(1'b1, `REG_START_DLY, 32'h0000_0002);
    apb(1'b1, `REG_DECEL_DLY, 32'h0000_0002);
    apb(1'b1, `REG_DC_TIME, 32'h0000_0004);
    apb(1'b1, `REG_FAULT_TIME, 32'h0000_0003);
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0003);
    rd(`REG_OUT_SEL, 32'h0000_7814);
    vec  <= 1'b1;
    flux <= 1'b1;
    spd  <= 16'h0020 + 16'($urandom_range(4095));
    cyc(4);
    `CHK(term_out, 2'b10)
    // Start without pre-excitation
    start <= 1'b1;
    cyc(10);
    `CHK(req, 1'b1)
    `CHK(term_out, 2'b01)
    `CHK(irq, 1'b1)
    rd(`REG_STATUS, 32'h0000_0001, 32'h0000_0005);
    apb(1'b1, `REG_IRQ_STAT, 32'h0000_0002);
    cyc(2);
    `CHK(irq, 1'b0)
    cyc(400);
    rd(`REG_STATUS, 32'h0000_0005, 32'h0000_0005);
    rd(`REG_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
    // Low set speed while running
    spd <= 16'h0005;
    cyc(400);
    rd(`REG_STATUS, 32'h0000_0005, 32'h0000_0005);
    // Stop by start release, speed feed
    spd   <= 16'h0020 + 16'($urandom_range(4095));
    cyc(4);
    start <= 1'b0;
    cyc(10);
    spd <= 16'h0005;
    cyc(20);
    `CHK(req, 1'b1)
    wait_req(1'b0);
    cyc(4);
    `CHK(dc, 1'b1)
    `CHK(dc_freq, 16'h0000)
    cyc(80);
    `CHK(dc, 1'b0)
    rd(`REG_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, `REG_IRQ_STAT, 32'h0000_0007);
    // Shutoff during the start delay
    start <= 1'b1;
    wait_req(1'b1);
    shut <= 1'b1;
    cyc(5);
    `CHK(req, 1'b0)
    `CHK(ramp, 1'b0)
    start <= 1'b0;
    cyc(5);
    shut <= 1'b0;
    cyc(60);
    // Pre-excitation first, then start inside the start delay
    lx <= 1'b1;
    cyc(10);
    `CHK(req, 1'b1)
    rd(`REG_STATUS, 32'h0000_0001, 32'h0000_0005);
    start <= 1'b1;
    cyc(10);
    rd(`REG_STATUS, 32'h0000_0005, 32'h0000_0005);
    // Stop with pre-excitation held: no reopen until it is dropped once
    cyc(300);
    start <= 1'b0;
    wait_req(1'b0);
    cyc(100);
    start <= 1'b1;
    cyc(40);
    `CHK(req, 1'b0)
    lx <= 1'b0;
    cyc(5);
    lx <= 1'b1;
    cyc(10);
    `CHK(req, 1'b1)
    cyc(300);
    lx    <= 1'b0;
    start <= 1'b0;
    wait_req(1'b0);
    cyc(100);
    // Position feed: a new feed clears the running decel delay
    pos   <= 1'b1;
    spd   <= 16'h0020 + 16'($urandom_range(4095));
    start <= 1'b1;
    wait_req(1'b1);
    cyc(300);
    tgt <= 1'b1;
    cyc(1);
    tgt <= 1'b0;
    spd <= 16'h0005;
    cyc(20);
    `CHK(req, 1'b1)
    cyc(30);
    feed <= 1'b1;
    cyc(1);
    feed <= 1'b0;
    cyc(400);
    `CHK(req, 1'b1)
    start <= 1'b0;
    cyc(20);
    `CHK(req, 1'b1)
    wait_req(1'b0);
    cyc(100);
    pos <= 1'b0;
    // Full-closed without vector control: no zero speed hold
    fc    <= 1'b1;
    start <= 1'b1;
    wait_req(1'b1);
    cyc(300);
    vec   <= 1'b0;
    start <= 1'b0;
    wait_req(1'b0);
    cyc(4);
    `CHK(dc, 1'b0)
    vec <= 1'b1;
    fc  <= 1'b0;
    cyc(100);
    // Feedback that never follows raises the fault
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, `REG_IRQ_STAT, 32'h0000_0007);
    stuck <= 1'b1;
    start <= 1'b1;
    wait_req(1'b1);
    cyc(10);
    `CHK(irq, 1'b0)
    cyc(600);
    rd(`REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
    `CHK(irq, 1'b1)
    end_of_test();
  end
endmodule
